// ### src/bfd_branch_field_decode.v
/*
 Branch and condition-register field decoder. Takes an instruction word and
 its address from fetch, and one cycle later presents the branch target,
 branch options, condition-bit and condition-field selects and record-form
 update request. Assumes fetch presents a word with a valid strobe and that
 the branch and condition logic accept results on every cycle.
*/
// Operation
// - Relative target: displacement plus instruction address
// - Absolute target: sign-extended displacement used directly
// - Conditional displacement: bits 16-29, shifted, sign-extended
// - Branch condition bit selected by bits 11-15
// - Branch options bits 6-10 passed onward
// - Logic first source bit from bits 11-15
// - Bit selects 0-31, field selects 0-7
// - Record form also updates a condition field
// - Record bit 31: one updates, zero not
// - Long displacement: bits 6-29, shifted, sign-extended
`timescale 1ns/10ps
`include "bfd_consts.vh"

module bfd_branch_field_decode (
    input wire CLK_I,
    input wire RST_I,
    input wire INSTR_VALID_I,
    input wire [31:0] INSTR_WORD_I,
    input wire [31:0] CURRENT_INSTR_ADDRESS_I,
    output wire DEC_VALID_O,
    output wire [31:0] EFFECTIVE_TARGET_O,
    output wire IS_BRANCH_O,
    output wire IS_COND_BRANCH_O,
    output wire ABSOLUTE_TARGET_BIT_O,
    output wire [4:0] BRANCH_OPTIONS_FIELD_O,
    output wire [4:0] COND_BIT_SELECT_O,
    output wire IS_CR_LOGIC_O,
    output wire [4:0] LOGIC_SRC_BIT_FIRST_O,
    output wire [4:0] LOGIC_SRC_BIT_SECOND_O,
    output wire [4:0] LOGIC_DST_BIT_O,
    output wire [2:0] CR_FIELD_DST_O,
    output wire [2:0] CR_FIELD_SRC_O,
    output wire RECORD_FLAG_O,
    output wire CR_FIELD_UPDATE_O
);

    // ==========================================================================
    // Bit reordering: instruction bit n lives at vector index 31-n
    wire [31:0] w;
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_swap
            assign w[gi] = INSTR_WORD_I[31-gi];
        end
    endgenerate
    // w[k] is instruction bit k, so a field first:last is {w[first], ..., w[last]}

    // ==========================================================================
    // Field extraction
    wire [5:0] opcd = {w[0], w[1], w[2], w[3], w[4], w[5]};
    wire [9:0] xop = {w[21], w[22], w[23], w[24], w[25], w[26], w[27], w[28], w[29], w[30]};
    wire [4:0] f_6_10 = {w[6], w[7], w[8], w[9], w[10]};
    wire [4:0] f_11_15 = {w[11], w[12], w[13], w[14], w[15]};
    wire [4:0] f_16_20 = {w[16], w[17], w[18], w[19], w[20]};
    wire [2:0] f_6_8 = f_6_10[4:2];
    wire [2:0] f_11_13 = f_11_15[4:2];
    // Low-numbered instruction bits sit in the high part of the value
    wire [13:0] cond_branch_displacement = INSTR_WORD_I[15:2];
    wire [23:0] long_branch_displacement = INSTR_WORD_I[25:2];
    wire absolute_target_bit = w[`BFD_ABS_BIT];
    wire record_flag = w[`BFD_REC_BIT];

    // ==========================================================================
    // Classification
    wire is_b = (opcd == `BFD_OP_B);
    wire is_bc = (opcd == `BFD_OP_BC);
    wire is_crgrp = (opcd == `BFD_OP_CRGRP);
    wire is_bcreg = is_crgrp && ((xop == `BFD_XO_BCLR) || (xop == `BFD_XO_BCCTR));
    wire is_mcrf = is_crgrp && (xop == `BFD_XO_MCRF);
    // Remaining group members with bits 27-29 clear and bit 30 set cover the eight bit-logic ops
    wire is_crlogic = is_crgrp && !is_bcreg && !is_mcrf && (xop[3:0] == 4'h1);
    // Branches use bit 31 as the link bit, so they never record
    wire rec_capable = !(is_b || is_bc || is_crgrp);

    // ==========================================================================
    // Target formation
    wire [31:0] cdisp_ext = {{16{cond_branch_displacement[13]}}, cond_branch_displacement, 2'b00};
    wire [31:0] ldisp_ext = {{6{long_branch_displacement[23]}}, long_branch_displacement, 2'b00};
    wire [31:0] disp_ext = is_b ? ldisp_ext : cdisp_ext;
    reg [31:0] effective_target_nxt;
    always @* begin
        if (absolute_target_bit) begin
            effective_target_nxt = disp_ext;
        end else begin
            effective_target_nxt = CURRENT_INSTR_ADDRESS_I + disp_ext;
        end
    end

    // ==========================================================================
    // Next values of the registered outputs
    // Class flags and update are gated by valid; absolute is gated by the b/bc class only; record and operand fields pass for any word, so a
    // consumer must qualify them with its own class flag
    wire dec_valid_nxt = INSTR_VALID_I;
    wire is_branch_nxt = INSTR_VALID_I && (is_b || is_bc || is_bcreg);
    wire is_cond_branch_nxt = INSTR_VALID_I && (is_bc || is_bcreg);
    wire absolute_target_bit_nxt = absolute_target_bit && (is_b || is_bc);
    wire [4:0] branch_options_field_nxt = f_6_10;
    wire [4:0] cond_bit_select_nxt = f_11_15;
    wire is_cr_logic_nxt = INSTR_VALID_I && is_crlogic;
    wire [4:0] logic_src_bit_first_nxt = f_11_15;
    wire [4:0] logic_src_bit_second_nxt = f_16_20;
    wire [4:0] logic_dst_bit_nxt = f_6_10;
    wire [2:0] cr_field_dst_nxt = f_6_8;
    wire [2:0] cr_field_src_nxt = f_11_13;
    wire record_flag_nxt = record_flag;
    wire cr_field_update_nxt = INSTR_VALID_I && rec_capable && record_flag;

    // ==========================================================================
    // Output registers
    // One register per output keeps each field traceable; all share one
    // clock and reset, so a result set always moves as one
    bfd_field_reg #(
        .WIDTH(1)
    ) u_dec_valid (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(dec_valid_nxt),
        .q_o(DEC_VALID_O)
    );

    bfd_field_reg #(
        .WIDTH(32)
    ) u_effective_target (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(effective_target_nxt),
        .q_o(EFFECTIVE_TARGET_O)
    );

    bfd_field_reg #(
        .WIDTH(1)
    ) u_is_branch (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(is_branch_nxt),
        .q_o(IS_BRANCH_O)
    );

    bfd_field_reg #(
        .WIDTH(1)
    ) u_is_cond_branch (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(is_cond_branch_nxt),
        .q_o(IS_COND_BRANCH_O)
    );

    bfd_field_reg #(
        .WIDTH(1)
    ) u_absolute_target_bit (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(absolute_target_bit_nxt),
        .q_o(ABSOLUTE_TARGET_BIT_O)
    );

    bfd_field_reg #(
        .WIDTH(5)
    ) u_branch_options_field (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(branch_options_field_nxt),
        .q_o(BRANCH_OPTIONS_FIELD_O)
    );

    bfd_field_reg #(
        .WIDTH(5)
    ) u_cond_bit_select (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(cond_bit_select_nxt),
        .q_o(COND_BIT_SELECT_O)
    );

    bfd_field_reg #(
        .WIDTH(1)
    ) u_is_cr_logic (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(is_cr_logic_nxt),
        .q_o(IS_CR_LOGIC_O)
    );

    bfd_field_reg #(
        .WIDTH(5)
    ) u_logic_src_bit_first (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(logic_src_bit_first_nxt),
        .q_o(LOGIC_SRC_BIT_FIRST_O)
    );

    bfd_field_reg #(
        .WIDTH(5)
    ) u_logic_src_bit_second (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(logic_src_bit_second_nxt),
        .q_o(LOGIC_SRC_BIT_SECOND_O)
    );

    bfd_field_reg #(
        .WIDTH(5)
    ) u_logic_dst_bit (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(logic_dst_bit_nxt),
        .q_o(LOGIC_DST_BIT_O)
    );

    bfd_field_reg #(
        .WIDTH(3)
    ) u_cr_field_dst (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(cr_field_dst_nxt),
        .q_o(CR_FIELD_DST_O)
    );

    bfd_field_reg #(
        .WIDTH(3)
    ) u_cr_field_src (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(cr_field_src_nxt),
        .q_o(CR_FIELD_SRC_O)
    );

    bfd_field_reg #(
        .WIDTH(1)
    ) u_record_flag (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(record_flag_nxt),
        .q_o(RECORD_FLAG_O)
    );

    bfd_field_reg #(
        .WIDTH(1)
    ) u_cr_field_update (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(cr_field_update_nxt),
        .q_o(CR_FIELD_UPDATE_O)
    );

endmodule

// ### src/bfd_consts.vh
/*
 Shared constants for the branch field decoder: instruction field positions
 (given in the big-endian numbering used by the instruction set, bit 0 = MSB)
 and opcode values. Assumes the includer is plain Verilog-2005.
*/
`ifndef BFD_CONSTS_VH
`define BFD_CONSTS_VH

// ==========================================================================
// Field positions, instruction numbering (bit 0 is the MSB)
`define BFD_OPCD_FIRST 0
`define BFD_OPCD_LAST 5
`define BFD_BOPT_FIRST 6
`define BFD_BOPT_LAST 10
`define BFD_CBIT_FIRST 11
`define BFD_CBIT_LAST 15
`define BFD_CBIT2_FIRST 16
`define BFD_CBIT2_LAST 20
`define BFD_CDISP_FIRST 16
`define BFD_CDISP_LAST 29
`define BFD_LDISP_FIRST 6
`define BFD_LDISP_LAST 29
`define BFD_XOP_FIRST 21
`define BFD_XOP_LAST 30
`define BFD_ABS_BIT 30
`define BFD_REC_BIT 31
`define BFD_CFLD_FIRST 6
`define BFD_CFLD_LAST 8

// ==========================================================================
// Primary and extended opcodes used to classify the word
`define BFD_OP_BC 6'h10
`define BFD_OP_B 6'h12
`define BFD_OP_CRGRP 6'h13
`define BFD_XO_MCRF 10'h000
`define BFD_XO_BCLR 10'h010
`define BFD_XO_BCCTR 10'h210

// ==========================================================================
// Reset values
`define BFD_WORD_RST 32'h0000_0000

`endif

// ### src/bfd_field_reg.v
/*
 Holds the decoded outputs in a bank of flip-flops so that every data output
 of the decoder comes from a register. Assumes a synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "bfd_consts.vh"

module bfd_field_reg #(
    parameter WIDTH = 32
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);

    // ==========================================================================
    // Storage
    always @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= {WIDTH{1'b0}};
        end else begin
            q_o <= d_i;
        end
    end

endmodule

// ### testbench/bfd_chk_asserts.sv
/* Port checker for the branch field decoder.
 Assumes one clock, synchronous active-high reset, bound below. */
`timescale 1ns/10ps
module bfd_chk (
    input wire CLK_I,
    input wire RST_I,
    input wire INSTR_VALID_I,
    input wire [31:0] INSTR_WORD_I,
    input wire [31:0] CURRENT_INSTR_ADDRESS_I,
    input wire DEC_VALID_O,
    input wire [31:0] EFFECTIVE_TARGET_O,
    input wire IS_COND_BRANCH_O,
    input wire [4:0] BRANCH_OPTIONS_FIELD_O,
    input wire [4:0] COND_BIT_SELECT_O,
    input wire [4:0] LOGIC_SRC_BIT_FIRST_O,
    input wire RECORD_FLAG_O,
    input wire CR_FIELD_UPDATE_O
);
    wire [5:0] op = INSTR_WORD_I[31:26];
    wire [31:0] cd = {{16{INSTR_WORD_I[15]}}, INSTR_WORD_I[15:2], 2'b00};
    wire [31:0] ld = {{6{INSTR_WORD_I[25]}}, INSTR_WORD_I[25:2], 2'b00};
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    a_opt_field: assert property (1 |=> BRANCH_OPTIONS_FIELD_O == $past(INSTR_WORD_I[25:21]))
        else $error("options field wrong");
    a_cond_bit: assert property (1 |=> COND_BIT_SELECT_O == $past(INSTR_WORD_I[20:16]))
        else $error("condition bit select wrong");
    a_logic_src: assert property (1 |=> LOGIC_SRC_BIT_FIRST_O == $past(INSTR_WORD_I[20:16]))
        else $error("logic source bit wrong");
    a_rec_flag: assert property (1 |=> RECORD_FLAG_O == $past(INSTR_WORD_I[0]))
        else $error("record flag wrong");
    a_rel_target: assert property (INSTR_VALID_I && op == 6'h10 && !INSTR_WORD_I[1]
        |=> EFFECTIVE_TARGET_O == $past(cd + CURRENT_INSTR_ADDRESS_I))
        else $error("relative target wrong");
    a_abs_long: assert property (INSTR_VALID_I && op == 6'h12 && INSTR_WORD_I[1]
        |=> EFFECTIVE_TARGET_O == $past(ld))
        else $error("absolute target wrong");
    a_rec_update: assert property (INSTR_VALID_I && op == 6'h1F |=> CR_FIELD_UPDATE_O == $past(INSTR_WORD_I[0]))
        else $error("field update wrong");
    a_cond_class: assert property (INSTR_VALID_I && op == 6'h10 |=> IS_COND_BRANCH_O && DEC_VALID_O)
        else $error("conditional branch missed");
    c_abs: cover property (INSTR_VALID_I && op == 6'h12 && INSTR_WORD_I[1]);
    c_rec: cover property (INSTR_VALID_I && op == 6'h1F && INSTR_WORD_I[0]);
    c_rel: cover property (INSTR_VALID_I && op == 6'h10 && !INSTR_WORD_I[1]);
endmodule
bind bfd_branch_field_decode bfd_chk u_chk (.*);

// ### testbench/bfd_fetch_model.sv
/* Fetch stage model: hands one word a cycle on request.
 Assumes requests change just after a rising edge. */
`timescale 1ns/10ps
module bfd_fetch_model (
    input wire clk_i,
    input wire send_i,
    input wire [31:0] word_i,
    input wire [31:0] addr_i,
    output reg valid_o = 1'b0,
    output reg [31:0] word_o = 32'h0,
    output reg [31:0] addr_o = 32'h0
);
    // Idle lines flip so stale fields never pass as a match
    always @(posedge clk_i) begin
        valid_o <= send_i;
        word_o <= send_i ? word_i : ~word_o;
        addr_o <= send_i ? addr_i : ~addr_o;
    end
endmodule

// ### testbench/testbench.sv
/* Self-checking bench for the branch field decoder.
 Assumes the fetch model and checker are compiled first. */
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, send = 1'b0, fv, dv, br, cb, ab, cl, rf, up;
    logic [31:0] word = 32'h0, addr = 32'h0, fw, fa, tgt, w;
    logic [4:0] bo, bi, sa, sb, db;
    logic [2:0] fd, fs;
    logic [68:0] got, want;
    logic [68:0] exp_q[$];
    logic [5:0] ops[4] = '{6'h10, 6'h12, 6'h13, 6'h1F};
    int failures = 0, checks_done = 0, cycles = 0;
    always #2 clk = ~clk;
    bfd_fetch_model fm (.clk_i(clk), .send_i(send), .word_i(word), .addr_i(addr), .valid_o(fv), .word_o(fw),
        .addr_o(fa));
    bfd_branch_field_decode dut (.CLK_I(clk), .RST_I(rst), .INSTR_VALID_I(fv), .INSTR_WORD_I(fw),
        .CURRENT_INSTR_ADDRESS_I(fa), .DEC_VALID_O(dv), .EFFECTIVE_TARGET_O(tgt), .IS_BRANCH_O(br),
        .IS_COND_BRANCH_O(cb), .ABSOLUTE_TARGET_BIT_O(ab), .BRANCH_OPTIONS_FIELD_O(bo), .COND_BIT_SELECT_O(bi),
        .IS_CR_LOGIC_O(cl), .LOGIC_SRC_BIT_FIRST_O(sa), .LOGIC_SRC_BIT_SECOND_O(sb), .LOGIC_DST_BIT_O(db),
        .CR_FIELD_DST_O(fd), .CR_FIELD_SRC_O(fs), .RECORD_FLAG_O(rf), .CR_FIELD_UPDATE_O(up));
    function automatic logic [68:0] model(logic [31:0] v, logic [31:0] a);
        logic [5:0] op;
        logic [31:0] d;
        logic c, lb;
        op = v[31:26];
        c = op == 6'h10 || (op == 6'h13 && (v[10:1] == 10'h010 || v[10:1] == 10'h210));
        lb = op == 6'h12 || op == 6'h10;
        d = op == 6'h12 ? {{6{v[25]}}, v[25:2], 2'b00} : {{16{v[15]}}, v[15:2], 2'b00};
        return {v[1] ? d : d + a, c || op == 6'h12, c, lb & v[1], op == 6'h13 && v[4:1] == 4'h1,
            v[25:21], v[20:16], v[20:16], v[15:11], v[25:21], v[25:23], v[20:18], v[0],
            v[0] && !lb && op != 6'h13};
    endfunction
    task automatic issue(logic [31:0] v, logic [31:0] a);
        @(posedge clk);
        send <= 1'b1;
        word <= v;
        addr <= a;
        exp_q.push_back(model(v, a));
    endtask
    task automatic idle();
        @(posedge clk);
        send <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        #1;
        got = {tgt, br, cb, ab, cl, bo, bi, sa, sb, db, fd, fs, rf, up};
        if (dv === 1'b1) begin
            if (exp_q.size() == 0) begin
                $display("[FAIL] %0t: result with nothing expected", $time);
                failures++;
            end else begin
                want = exp_q.pop_front();
                checks_done++;
                if (got[68:37] !== want[68:37]) begin
                    $display("[FAIL] %0t: target differs", $time);
                    failures++;
                end
                if (got[36:0] !== want[36:0]) begin
                    $display("[FAIL] %0t: decoded fields differ", $time);
                    failures++;
                end
            end
        end else if (dv !== 1'b0 || (!rst && exp_q.size() > 2)) begin
            $display("[FAIL] %0t: valid out of step", $time);
            failures++;
        end
        if (++cycles > 3000) begin
            $display("[FAIL] %0t: timeout", $time);
            failures++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(68));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        issue(32'h4800_0010, 32'h0000_0100);
        issue(32'h4182_FFF8, 32'h0000_0200);
        issue(32'h4A00_0002, 32'h0000_0400);
        issue(32'h4200_8002, 32'hFFFF_FFF0);
        issue(32'h4C43_2202, 32'h0000_0010);
        issue(32'h7C00_0379, 32'h0000_0020);
        issue(32'h7C00_0378, 32'h0000_0024);
        issue(32'h4C00_0021, 32'h0000_0028);
        idle();
        $display("Directed test done");
        repeat (400) begin
            w = $urandom;
            w[31:26] = ops[$urandom % 4];
            if ($urandom % 4 == 0) idle();
            else issue(w, $urandom & 32'hFFFF_FFFC);
        end
        repeat (4) idle();
        $display("Random test done");
        if (exp_q.size() != 0) begin
            $display("[FAIL] %0t: results missing", $time);
            failures++;
        end
        end_of_test();
    end
endmodule
